// *** core/its_timer.sv ***
`timescale 1ns/10ps
// Functional notes
// - sixteen compare channels, own event each
// - two sync outputs, pin and internal
// - four sync modes incl. acknowledge variants
// - router fans one source to many
// - latch input fed from router output
// - latch incoming sync, correct measured delay
// - align via sync, capture, compensation register
// - both chips same clock and increment
// - one independent dispatcher per core
// - dispatcher general or receive/transmit mode
// - general mode lets higher task preempt
// - save pc and flags, supply new pc
// - termination restores saved context
// - tasks mapped to compare/capture/host events
// - wrap to start at compare zero
// - non-ack modes: sync high for width field plus one
// - repeat enable clear gives one-shot; here mode bit zero set gives one-shot, clear gives cyclic
// - correction = capture - compare one - delay
module its_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // sync, router and pins
  input wire logic gpio_in,
  output logic [its_pkg::NSYNC-1:0] sync_out,
  output logic [its_pkg::NROUTE-1:0] route_out,
  output logic [its_pkg::NCMP-1:0] cmp_evt,
  output logic cap_evt,
  // realtime core
  input wire logic [its_pkg::NHOST-1:0] host_evt,
  input wire its_pkg::its_ctx_t core_ctx,
  input wire logic core_done,
  output its_pkg::its_ctx_t load_ctx,
  output logic core_load,
  output logic [2:0] task_lvl
);
  logic [its_pkg::CNT_W-1:0] count, prev_count, comp, cap;
  logic [its_pkg::CNT_W-1:0] cmp [its_pkg::NCMP];
  logic [its_pkg::NCMP-1:0] cmp_en, hit;
  logic cnt_en, wrap, comp_pend, cap_en, latch_prev, sync_en;
  logic [7:0] inc;
  logic [its_pkg::NSYNC-1:0] sen, armed;
  logic [1:0] smode [its_pkg::NSYNC];
  its_pkg::its_sync_t sst [its_pkg::NSYNC];
  logic [its_pkg::HPW_W-1:0] hpw;
  logic [its_pkg::HPW_W-1:0] wcnt [its_pkg::NSYNC];
  logic [1:0] rsel [its_pkg::NROUTE];
  logic [1:0] dmode;
  logic [its_pkg::NTASK-1:0] ten, pend;
  logic [its_pkg::PC_W-1:0] tpc [its_pkg::NTASK];
  logic [4:0] tsrc [its_pkg::NTASK];
  its_pkg::its_ctx_t save [its_pkg::NTASK];
  logic [2:0] save_lvl [its_pkg::NTASK];
  logic [31:0] ev;
  logic [2:0] pick;
  logic launch, wr_sync;
  logic [3:0] route_src;

  function automatic logic [2:0] first_one(input logic [3:0] v);
    first_one = its_pkg::LVL_BASE;
    for (int i = 3; i >= 0; i--)
    begin
      if (v[i])
        first_one = 3'(i);
    end
  endfunction

  function automatic logic is_ack(input logic [1:0] m);
    is_ack = (m == its_pkg::M_CYC_ACK) || (m == its_pkg::M_ONE_ACK);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  assign wr_sync = wr && addr == its_pkg::A_SYNC_CTRL;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_en <= 1'b0;
      wrap <= 1'b0;
      inc <= its_pkg::INC_RST;
      cmp_en <= '0;
      cap_en <= 1'b0;
      sync_en <= 1'b0;
      sen <= '0;
      hpw <= its_pkg::HPW_RST;
      dmode <= its_pkg::D_OFF;
      ten <= '0;
      for (int i = 0; i < its_pkg::NSYNC; i++)
        smode[i] <= its_pkg::M_CYCLIC;
      for (int i = 0; i < its_pkg::NROUTE; i++)
        rsel[i] <= 2'h0;
      for (int i = 0; i < its_pkg::NCMP; i++)
        cmp[i] <= '0;
      for (int i = 0; i < its_pkg::NTASK; i++)
      begin
        tpc[i] <= '0;
        tsrc[i] <= '0;
      end
    end
    else if (wr)
    begin
      case (addr)
        its_pkg::A_GLOBAL:
        begin
          cnt_en <= wdata[its_pkg::F_CNT_EN];
          wrap <= wdata[its_pkg::F_WRAP];
          inc <= wdata[its_pkg::F_INC_LO +: 8];
        end
        its_pkg::A_CMP_EN: cmp_en <= wdata[15:0];
        its_pkg::A_CAP_CFG: cap_en <= wdata[0];
        its_pkg::A_SYNC_CTRL:
        begin
          sync_en <= wdata[its_pkg::F_SYNC_EN];
          sen <= wdata[its_pkg::F_SEN_LO +: 2];
          smode[0] <= wdata[its_pkg::F_MODE_LO +: 2];
          smode[1] <= wdata[its_pkg::F_MODE_LO + 2 +: 2];
        end
        its_pkg::A_SYNC_WIDTH: hpw <= wdata[its_pkg::HPW_W-1:0];
        its_pkg::A_ROUTE:
          for (int i = 0; i < its_pkg::NROUTE; i++)
            rsel[i] <= wdata[2*i +: 2];
        its_pkg::A_TASK_CFG:
        begin
          dmode <= wdata[1:0];
          ten <= wdata[its_pkg::F_TEN_LO +: 4];
        end
        default:
        begin
          if (addr[7:6] == 2'h1)
            cmp[addr[5:2]] <= wdata;
          else if (addr[7:4] == 4'h8)
            tpc[addr[3:2]] <= wdata[its_pkg::PC_W-1:0];
          else if (addr[7:4] == 4'h9)
            tsrc[addr[3:2]] <= wdata[4:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter, compensation, compare
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      prev_count <= '0;
    end
    else
    begin
      prev_count <= count;
      if (wr && addr == its_pkg::A_COUNT)
        count <= wdata;
      else if (cnt_en)
        count <= (wrap && count == cmp[0] ? '0 : count + inc)
          + (comp_pend ? comp : '0);
    end
  end

  // a new write in the applying cycle stays pending: set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp <= '0;
      comp_pend <= 1'b0;
    end
    else if (wr && addr == its_pkg::A_COMP)
    begin
      comp <= wdata;
      comp_pend <= 1'b1;
    end
    else if (cnt_en && !(wr && addr == its_pkg::A_COUNT))
      comp_pend <= 1'b0;
  end

  // a hit needs the count to have moved, so a stalled count fires once
  always_comb
  begin
    for (int i = 0; i < its_pkg::NCMP; i++)
      hit[i] = cmp_en[i] && count == cmp[i] && count != prev_count;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cmp_evt <= '0;
    else
      cmp_evt <= hit;
  end

  ////////////////////////////////////////////////////////////////////
  // sync generators, triggered by compare one and two
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_out <= '0;
      armed <= '0;
      for (int s = 0; s < its_pkg::NSYNC; s++)
      begin
        sst[s] <= its_pkg::S_IDLE;
        wcnt[s] <= '0;
      end
    end
    else
    begin
      for (int s = 0; s < its_pkg::NSYNC; s++)
      begin
        if (hit[s+1] && sync_en && sen[s] && armed[s]
            && sst[s] != its_pkg::S_HIGH)
        begin
          sst[s] <= its_pkg::S_HIGH;
          sync_out[s] <= 1'b1;
          wcnt[s] <= hpw;
          if (smode[s][0])
            armed[s] <= 1'b0;
        end
        else
        begin
          case (sst[s])
            its_pkg::S_IDLE: sync_out[s] <= 1'b0;
            its_pkg::S_HIGH:
              if (wcnt[s] == '0)
              begin
                sst[s] <= is_ack(smode[s]) ? its_pkg::S_HOLD
                  : its_pkg::S_IDLE;
                sync_out[s] <= is_ack(smode[s]);
              end
              else
                wcnt[s] <= wcnt[s] - 1'b1;
            its_pkg::S_HOLD:
              if (wr_sync && wdata[its_pkg::F_ACK_LO + s])
              begin
                sst[s] <= its_pkg::S_IDLE;
                sync_out[s] <= 1'b0;
              end
            default:
            begin
              sst[s] <= its_pkg::S_IDLE;
              sync_out[s] <= 1'b0;
            end
          endcase
        end
        // rewriting the control re-arms a one-shot generator
        if (wr_sync)
          armed[s] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // router and latch capture
  // source order: constant zero, general pin, first sync, second sync
  assign route_src = {sync_out, gpio_in, 1'b0};
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      route_out <= '0;
    else
      for (int i = 0; i < its_pkg::NROUTE; i++)
        route_out[i] <= route_src[rsel[i]];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_prev <= 1'b0;
      cap <= '0;
      cap_evt <= 1'b0;
    end
    else
    begin
      latch_prev <= route_out[0];
      cap_evt <= cap_en && route_out[0] && !latch_prev;
      if (cap_en && route_out[0] && !latch_prev)
        cap <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // task dispatcher; lower task index is higher priority
  assign ev = {7'h00, host_evt, cap_evt, cmp_evt};
  assign pick = first_one(pend);
  assign launch = !core_done && pick != its_pkg::LVL_BASE
    && ((dmode == its_pkg::D_GP && pick < task_lvl)
    || (dmode == its_pkg::D_RXTX && task_lvl == its_pkg::LVL_BASE));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pend <= '0;
    else
      for (int k = 0; k < its_pkg::NTASK; k++)
        if (ten[k] && ev[tsrc[k]])
          pend[k] <= 1'b1;
        else if (launch && pick == 3'(k))
          pend[k] <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      task_lvl <= its_pkg::LVL_BASE;
      core_load <= 1'b0;
      load_ctx <= '0;
      for (int k = 0; k < its_pkg::NTASK; k++)
      begin
        save[k] <= '0;
        save_lvl[k] <= its_pkg::LVL_BASE;
      end
    end
    else
    begin
      core_load <= 1'b0;
      if (core_done && task_lvl != its_pkg::LVL_BASE)
      begin
        load_ctx <= save[task_lvl[1:0]];
        task_lvl <= save_lvl[task_lvl[1:0]];
        core_load <= 1'b1;
      end
      else if (launch)
      begin
        save[pick[1:0]] <= core_ctx;
        save_lvl[pick[1:0]] <= task_lvl;
        load_ctx <= '{pc: tpc[pick[1:0]], flags: '0};
        task_lvl <= pick;
        core_load <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register reads, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd)
    begin
      case (addr)
        its_pkg::A_GLOBAL:
          rdata <= {16'h0000, inc, 6'h00, wrap, cnt_en};
        its_pkg::A_COUNT: rdata <= count;
        its_pkg::A_COMP: rdata <= comp;
        its_pkg::A_CMP_EN: rdata <= {16'h0000, cmp_en};
        its_pkg::A_CAP_CFG: rdata <= {31'h0, cap_en};
        its_pkg::A_CAP: rdata <= cap;
        its_pkg::A_SYNC_CTRL:
          rdata <= {24'h0, smode[1], smode[0], 1'b0, sen, sync_en};
        its_pkg::A_SYNC_WIDTH: rdata <= {16'h0000, hpw};
        its_pkg::A_ROUTE:
          rdata <= {24'h0, rsel[3], rsel[2], rsel[1], rsel[0]};
        its_pkg::A_TASK_CFG: rdata <= {24'h0, ten, 2'h0, dmode};
        its_pkg::A_STATUS:
          rdata <= {20'h0, pend, 1'b0, task_lvl, comp_pend, 1'b0,
            sync_out};
        default:
          if (addr[7:6] == 2'h1)
            rdata <= cmp[addr[5:2]];
          else if (addr[7:4] == 4'h8)
            rdata <= {16'h0000, tpc[addr[3:2]]};
          else if (addr[7:4] == 4'h9)
            rdata <= {27'h0, tsrc[addr[3:2]]};
          else
            rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  logic [its_pkg::HPW_W:0] hi_len;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hi_len <= '0;
    else
      hi_len <= sync_out[0] ? hi_len + 1'b1 : '0;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_launch;
    launch ##1 core_load;
  endsequence

  a_wrap_zero: assert property (cnt_en && wrap && count == cmp[0]
    && !comp_pend && !wr |=> count == '0)
    else $error("counter did not wrap at compare zero");
  a_cmp_fire: assert property (cmp_en[1] && count == cmp[1]
    && count != $past(count) |=> cmp_evt[1])
    else $error("compare event missing");
  a_sync_width: assert property ($fell(sync_out[0])
    && !is_ack(smode[0]) && !$past(wr) |-> hi_len == hpw + 1'b1)
    else $error("sync pulse width wrong");
  a_oneshot_disarm: assert property (smode[0] == its_pkg::M_ONESHOT
    && $rose(sync_out[0]) && !$past(wr_sync) |-> !armed[0])
    else $error("one-shot sync stayed armed");
  a_capture_count: assert property (cap_en && route_out[0]
    && !latch_prev |=> cap_evt && cap == $past(count))
    else $error("capture did not take the count");
  a_comp_once: assert property (comp_pend && cnt_en && !wr
    |=> !comp_pend)
    else $error("compensation applied more than once");
  a_preempt_save: assert property (s_launch |->
    save[task_lvl[1:0]] == $past(core_ctx)
    && load_ctx.pc == tpc[task_lvl[1:0]])
    else $error("preemption context wrong");
  a_done_restore: assert property (core_done
    && task_lvl != its_pkg::LVL_BASE |=> core_load
    && task_lvl == $past(save_lvl[task_lvl[1:0]]))
    else $error("termination did not restore");
endmodule

// *** core/its_pkg.sv ***
package its_pkg;
  localparam int CNT_W = 32;
  localparam int NCMP = 16;
  localparam int NSYNC = 2;
  localparam int NROUTE = 4;
  localparam int NTASK = 4;
  localparam int NHOST = 8;
  localparam int PC_W = 16;
  localparam int FL_W = 8;
  localparam int HPW_W = 16;
  // register byte addresses
  localparam logic [7:0] A_GLOBAL = 8'h00;
  localparam logic [7:0] A_COUNT = 8'h04;
  localparam logic [7:0] A_COMP = 8'h08;
  localparam logic [7:0] A_CMP_EN = 8'h0C;
  localparam logic [7:0] A_CAP_CFG = 8'h10;
  localparam logic [7:0] A_CAP = 8'h14;
  localparam logic [7:0] A_SYNC_CTRL = 8'h18;
  localparam logic [7:0] A_SYNC_WIDTH = 8'h1C;
  localparam logic [7:0] A_ROUTE = 8'h20;
  localparam logic [7:0] A_TASK_CFG = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_CMP_BASE = 8'h40;
  localparam logic [7:0] A_TPC_BASE = 8'h80;
  localparam logic [7:0] A_TSRC_BASE = 8'h90;
  // field positions
  localparam int F_CNT_EN = 0;
  localparam int F_WRAP = 1;
  localparam int F_INC_LO = 8;
  localparam int F_SYNC_EN = 0;
  localparam int F_SEN_LO = 1;
  localparam int F_MODE_LO = 4;
  localparam int F_ACK_LO = 8;
  localparam int F_TEN_LO = 4;
  // reset values
  localparam logic [7:0] INC_RST = 8'h04;
  localparam logic [HPW_W-1:0] HPW_RST = 16'h0000;
  localparam logic [2:0] LVL_BASE = 3'h4;
  // sync generation modes
  localparam logic [1:0] M_CYCLIC = 2'h0;
  localparam logic [1:0] M_ONESHOT = 2'h1;
  localparam logic [1:0] M_CYC_ACK = 2'h2;
  localparam logic [1:0] M_ONE_ACK = 2'h3;
  // dispatcher modes
  localparam logic [1:0] D_OFF = 2'h0;
  localparam logic [1:0] D_RXTX = 2'h1;
  localparam logic [1:0] D_GP = 2'h2;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_HIGH = 3'b010,
    S_HOLD = 3'b100
  } its_sync_t;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [FL_W-1:0] flags;
  } its_ctx_t;
endpackage

// *** sim/its_peer.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// peer chip timer: emits the loop sync pulse onto our general pin
module its_peer #(
  parameter int PERIOD = 40,
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic run,
  // sync line
  output logic sync_line
);
  int cnt;
  // one pulse per loop period, same clock and rate as ours
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      sync_line <= 1'b0;
    end
    else if (run)
    begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync_line <= (cnt < WIDTH);
    end
    else
    begin
      cnt <= 0;
      sync_line <= 1'b0;
    end
  end
endmodule

// *** sim/interchip_time_sync_timer_tb.sv ***
`timescale 1ns/10ps
module interchip_time_sync_timer_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic gpio_in;
  logic peer_run = 1'b0;
  logic [1:0] sync_out;
  logic [3:0] route_out;
  logic [15:0] cmp_evt;
  logic cap_evt;
  logic [7:0] host_evt = 8'h00;
  its_pkg::its_ctx_t core_ctx = '0;
  logic core_done = 1'b0;
  its_pkg::its_ctx_t load_ctx;
  logic core_load;
  logic [2:0] task_lvl;
  logic rd_q = 1'b0;
  logic sy_q = 1'b0;
  int fails = 0;
  int compares = 0;
  int sy_rise = 0;
  int hi_len = 0;
  int gap = 0;
  int cmp_n = 0;
  int chk_w = 0;
  int rise0 = 0;
  int evt0 = 0;
  int ro_rise = 0;
  int ro0 = 0;
  logic ro_q = 1'b0;
  logic [31:0] q_rd[$];
  its_pkg::its_ctx_t q_ctx[$];
  logic [2:0] q_lvl[$];
  its_pkg::its_ctx_t c0;
  its_pkg::its_ctx_t c1;
  logic [15:0] p0;
  logic [15:0] p1;
  logic [31:0] cv;

  always #25 clock = ~clock;

  its_peer i_peer (.clock(clock), .rst_n(rst_n), .run(peer_run),
    .sync_line(gpio_in));
  its_timer i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gpio_in(gpio_in),
    .sync_out(sync_out), .route_out(route_out), .cmp_evt(cmp_evt),
    .cap_evt(cap_evt), .host_evt(host_evt), .core_ctx(core_ctx),
    .core_done(core_done), .load_ctx(load_ctx), .core_load(core_load),
    .task_lvl(task_lvl));

  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // expected read value is queued, the monitor compares it
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    q_rd.push_back(exp);
    @(posedge clock);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] h, input logic d);
    @(posedge clock);
    host_evt <= h;
    core_done <= d;
    @(posedge clock);
    host_evt <= 8'h00;
    core_done <= 1'b0;
  endtask

  // bounded wait; a pulse is seen in the cycle it stands
  task automatic wait_evt(input bit use_load);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (((use_load ? core_load : cap_evt) !== 1'b1) && n < 200);
    if ((use_load ? core_load : cap_evt) !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic expect_load(input its_pkg::its_ctx_t c,
                             input logic [2:0] l);
    q_ctx.push_back(c);
    q_lvl.push_back(l);
  endtask

  //////////////////////////////////////////////////////////////////////
  // monitor: read data, context loads, sync pulse shape
  always @(posedge clock)
  begin
    rd_q <= rd;
    sy_q <= sync_out[0];
    ro_q <= route_out[1];
    gap <= gap + 1;
    if (rd_q)
      chk(rdata, q_rd.pop_front());
    // a load that nobody announced is a mismatch too
    if (core_load !== 1'b0)
    begin
      chk(q_ctx.size() > 0, 1'b1);
      if (q_ctx.size() > 0)
      begin
        chk({8'h00, load_ctx}, {8'h00, q_ctx.pop_front()});
        chk({29'h0, task_lvl}, {29'h0, q_lvl.pop_front()});
      end
    end
    if (cmp_evt[1] === 1'b1)
      cmp_n <= cmp_n + 1;
    if (route_out[1] === 1'b1 && !ro_q)
      ro_rise <= ro_rise + 1;
    if (sync_out[0] === 1'b1)
      hi_len <= hi_len + 1;
    else if (sy_q)
    begin
      if (chk_w != 0)
        chk(hi_len, 4);
      hi_len <= 0;
    end
    if (sync_out[0] === 1'b1 && !sy_q)
    begin
      // wrap at 60 with step 4 gives a 16 cycle loop
      if (sy_rise > 0 && chk_w == 2)
        chk(gap, 16);
      sy_rise <= sy_rise + 1;
      gap <= 1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(19692));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rreg(its_pkg::A_GLOBAL, 32'h00000400);
    rreg(its_pkg::A_STATUS, 32'h00000040);
    rreg(its_pkg::A_SYNC_WIDTH, 32'h00000000);
    rreg(8'hFC, 32'h00000000);
    // counter: increment 5 over 20 steps, compensation taken once
    wreg(its_pkg::A_COUNT, 32'h00000100);
    wreg(its_pkg::A_COMP, 32'h00000010);
    for (int k = 0; k < 2; k++)
    begin
      wreg(its_pkg::A_GLOBAL, 32'h00000501);
      cyc(8);
      wreg(its_pkg::A_GLOBAL, 32'h00000500);
    end
    rreg(its_pkg::A_COUNT, 32'h00000174);
    rreg(its_pkg::A_GLOBAL, 32'h00000500);
    // sync generation in every mode, compare one as trigger
    wreg(its_pkg::A_CMP_BASE, 32'h0000003C);
    wreg(8'h44, 32'h00000014);
    wreg(8'h48, 32'h00000028);
    wreg(its_pkg::A_CMP_EN, 32'h00000007);
    // second sync watched through router output one
    wreg(its_pkg::A_ROUTE, 32'h0000000C);
    wreg(its_pkg::A_SYNC_WIDTH, 32'h00000003);
    for (int m = 0; m < 4; m++)
    begin
      wreg(its_pkg::A_COUNT, 32'h00000000);
      wreg(its_pkg::A_SYNC_CTRL, (32'(m) << 4)
        | ((m == 0) ? 32'h00000007 : 32'h00000003));
      // counts live in the monitor; take a base here instead
      rise0 = sy_rise;
      evt0 = cmp_n;
      ro0 = ro_rise;
      chk_w <= (m == 0) ? 2 : (m == 1) ? 1 : 0;
      wreg(its_pkg::A_GLOBAL, 32'h00000403);
      cyc(70);
      wreg(its_pkg::A_GLOBAL, 32'h00000400);
      cyc(3);
      if (m == 0)
      begin
        chk(sy_rise - rise0 >= 4, 1);
        chk(cmp_n - evt0, sy_rise - rise0);
        // count 40 is met four times in 72 steps of four
        chk(ro_rise - ro0, 4);
      end
      if (m[0])
        chk(sy_rise - rise0, 1);
      if (m >= 2)
      begin
        chk(sync_out[0], 1'b1);
        wreg(its_pkg::A_SYNC_CTRL, (32'(m) << 4) | 32'h00000103);
        cyc(2);
        chk(sync_out[0], 1'b0);
      end
      chk(sync_out[1], 1'b0);
    end
    // capture of the peer pulse through router output zero
    wreg(its_pkg::A_ROUTE, 32'h00000001);
    wreg(its_pkg::A_CAP_CFG, 32'h00000001);
    cv = $urandom;
    wreg(its_pkg::A_COUNT, cv);
    peer_run <= 1'b1;
    wait_evt(1'b0);
    peer_run <= 1'b0;
    rreg(its_pkg::A_CAP, cv);
    // dispatcher, general mode: task 0 preempts task 1
    p0 = 16'($urandom);
    p1 = 16'($urandom);
    wreg(its_pkg::A_TPC_BASE, {16'h0000, p0});
    wreg(8'h84, {16'h0000, p1});
    wreg(its_pkg::A_TSRC_BASE, 32'h00000012);
    wreg(8'h94, 32'h00000011);
    wreg(its_pkg::A_TASK_CFG, 32'h00000032);
    c0.pc = 16'($urandom);
    c0.flags = 8'($urandom);
    c1.pc = 16'($urandom);
    c1.flags = 8'($urandom);
    core_ctx <= c0;
    expect_load({p1, 8'h00}, 3'h1);
    pulse(8'h01, 1'b0);
    wait_evt(1'b1);
    core_ctx <= c1; // only pc and flags are kept by hardware
    expect_load({p0, 8'h00}, 3'h0);
    pulse(8'h02, 1'b0);
    wait_evt(1'b1);
    expect_load(c1, 3'h1);
    pulse(8'h00, 1'b1);
    wait_evt(1'b1);
    expect_load(c0, 3'h4);
    pulse(8'h00, 1'b1);
    wait_evt(1'b1);
    // receive/transmit mode: no preemption while a task runs
    wreg(its_pkg::A_TASK_CFG, 32'h00000031);
    core_ctx <= c0;
    expect_load({p1, 8'h00}, 3'h1);
    pulse(8'h01, 1'b0);
    wait_evt(1'b1);
    pulse(8'h02, 1'b0);
    cyc(4);
    expect_load(c0, 3'h4);
    expect_load({p0, 8'h00}, 3'h0);
    pulse(8'h00, 1'b1);
    wait_evt(1'b1);
    wait_evt(1'b1);
    cyc(4);
    chk(q_ctx.size(), 0);
    test_done();
  end
endmodule
